// file: tb.sv
// Self-checking bench for the wake and system timers block
`timescale 1ns/1ps
module tb;
  typedef struct {logic [1:0] ps; logic en; logic [6:0] r; logic p; logic n; logic h;} wst_row_s;
  logic clk = 0, rst = 1, act = 0, oen = 0, txc = 0, sp = 0, pf = 0, tk = 0, fd = 0, ra = 0;
  logic hen = 0, clr, pin_n, host_interrupt_register, pend, txr, pact, rxi;
  logic [6:0] rule = 0, rs;
  logic [1:0] ps = 0;
  logic [31:0] cnt = 0;
  logic [15:0] pv = 0, idc = 0;
  logic [7:0] hd = 8'h03;
  int n_mismatch = 0, samples_checked = 0;
  wst_row_s rows [4] = '{'{2'h0, 1, 7'h10, 0, 1, 0}, '{2'h1, 1, 7'h15, 1, 0, 0},
    '{2'h2, 0, 7'h02, 1, 1, 1}, '{2'h3, 1, 7'h7F, 1, 0, 0}};
  // Design and host
  wst_timers wst_timers_inst (.REF_CLK_I(clk), .RST_I(rst), .WAKE_ACTION_I(act),
    .WAKE_RULE_I(rule), .POWER_STATE_FIELD_I(ps), .WAKE_OUTPUT_ENABLE_I(oen),
    .WAKE_CLEAR_BIT_I(clr), .HOST_SILENCE_COUNT_I(cnt), .TX_READY_CLEAR_I(txc),
    .START_PAUSE_I(sp), .PAUSE_FRAME_I(pf), .PAUSE_VALUE_I(pv), .IRQ_DELAY_COUNT_I(idc),
    .RX_BYTE_TICK_I(tk), .RX_FIRST_DATA_I(fd), .RX_IRQ_ACK_I(ra), .POWER_EVENT_OUT_N_O(pin_n),
    .HIR_WAKE_O(host_interrupt_register), .WAKE_PENDING_O(pend), .WAKE_RULE_STATUS_O(rs),
    .TX_READY_FLAG_O(txr), .PAUSE_ACTIVE_O(pact), .RX_IRQ_O(rxi));
  wst_host_model wst_host_model_inst (.clk_i(clk), .ack_en_i(hen), .dly_i(hd),
    .note_n_i(pin_n), .irq_i(host_interrupt_register), .clear_o(clr));
  // Clock of 4 ns
  always #2 clk = ~clk;
  // Verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Helpers for stepping, comparing and bounded waits
  task step;
    @(posedge clk);
    #1;
  endtask
  task ck(input bit ok);
    samples_checked++;
    if (!ok) begin
      n_mismatch++;
      $display("Error %0t output mismatch", $time);
    end
  endtask
  task automatic wb(ref logic s, input logic v, input int m);
    for (int j = 0; j < m && s !== v; j++) step;
    if (s !== v) begin
      n_mismatch++;
      $display("Error %0t wait timed out", $time);
      finish_test;
    end
  endtask
  task wake(input logic [6:0] r);
    rule = r;
    act = 1;
    step;
    act = 0;
    step;
  endtask
  // Main sequence: table of wake cases, then timers
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 0;
    ck(pin_n === 1 && {pend, host_interrupt_register, rs, txr, pact, rxi} === 0);
    hen = 1;
    foreach (rows[k]) begin
      ps = rows[k].ps;
      oen = rows[k].en;
      wake(rows[k].r);
      ck(pend === rows[k].p && pin_n === rows[k].n && host_interrupt_register === rows[k].h);
      if (rows[k].p) ck(rs === rows[k].r);
      wb(pend, 0, 10);
      ck(pin_n === 1 && host_interrupt_register === 0);
    end
    hen = 0;
    ps = 1;
    oen = 0;
    cnt = 6;
    wake(7'h55);
    repeat (6) begin ck(txr === 0); step; end
    ck(txr === 1);
    txc = 1;
    step;
    txc = 0;
    repeat (10) begin ck(txr === 0); step; end
    hen = 1;
    wb(pend, 0, 10);
    hd = 1;
    cnt = 30;
    wake(7'h10);
    repeat (40) step;
    ck(txr === 0 && pend === 0);
    pv = 16'h000A;
    sp = 1;
    step;
    sp = 0;
    step;
    repeat (7) begin ck(pact === 1); step; end
    wb(pact, 0, 8);
    pv = 16'h0004;
    pf = 1;
    step;
    pf = 0;
    step;
    ck(pact === 1);
    wb(pact, 0, 8);
    idc = 16'h0003;
    fd = 1;
    step;
    fd = 0;
    repeat (3) begin ck(rxi === 0); tk = 1; step; tk = 0; step; end
    wb(rxi, 1, 6);
    ra = 1;
    step;
    ra = 0;
    step;
    ck(rxi === 0);
    // Reset in mid-run with a wake still standing
    hen = 0;
    oen = 1;
    wake(7'h33);
    ck(pin_n === 0 && pend === 1);
    rst = 1;
    step;
    rst = 0;
    ck(pin_n === 1 && {pend, host_interrupt_register, rs, txr, pact, rxi} === 0);
    step;
    ck(pin_n === 1 && pend === 0);
    finish_test;
  end
endmodule // tb

// file: wst_cnt_if.sv
// Interface carrying load and status between top and countdown module
`timescale 1ns/1ps
interface wst_cnt_if #(parameter int W = 16);
  logic load;
  logic [W-1:0] value;
  logic busy;
  logic expire;
  modport ctl (output load, output value, input busy, input expire);
  modport cnt (input load, input value, output busy, output expire);
endinterface

// file: wst_countdown.sv
// Loadable countdown counter that stops at zero and pulses on expiry
`timescale 1ns/1ps
module wst_countdown #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  wst_cnt_if.cnt c
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic fired;
  logic next_fired;

  // Load wins over decrement; expiry pulses once on the step to zero
  always_comb begin
    next_count = count;
    next_fired = 1'b0;
    if (c.load) begin
      next_count = c.value;
    end else if (tick_i && count != '0) begin
      next_count = count - {{(W-1){1'b0}}, 1'b1};
      next_fired = (count == {{(W-1){1'b0}}, 1'b1});
    end
  end

  // Counter registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      fired <= 1'b0;
    end else begin
      count <= next_count;
      fired <= next_fired;
    end
  end

  assign c.busy = (count != '0);
  assign c.expire = fired;
endmodule // wst_countdown

// file: wst_host_model.sv
// Host model that acknowledges wake notifications after a delay
`timescale 1ns/1ps
module wst_host_model (
  input wire logic clk_i,
  input wire logic ack_en_i,
  input wire logic [7:0] dly_i,
  input wire logic note_n_i,
  input wire logic irq_i,
  output logic clear_o
);
  int cnt = 0;
  initial clear_o = 1'h0;
  // Waits dly_i cycles into a notification, then pulses the wake clear once
  always @(posedge clk_i) begin
    clear_o <= 1'h0;
    if (ack_en_i && (!note_n_i || irq_i)) begin
      cnt <= cnt + 1;
      if (cnt == dly_i) clear_o <= 1'h1;
    end else begin
      cnt <= 0;
    end
  end
endmodule // wst_host_model

// file: wst_pkg.sv
// Package of constants for the wake and system timers block
package wst_pkg;
  localparam int PS_W = 2;
  localparam int RULE_W = 7;
  localparam int HNR_W = 32;
  localparam int PAUSE_W = 16;
  localparam int IDLY_W = 16;
  localparam logic [1:0] PS_ACTIVE = 2'h0;
  localparam logic [RULE_W-1:0] RULE_RST = 7'h00;
  localparam logic [HNR_W-1:0] HNR_RST = 32'h00000000;
  localparam logic [PAUSE_W-1:0] PAUSE_RST = 16'h0000;
  localparam logic [IDLY_W-1:0] IDLY_RST = 16'h0000;
  typedef enum logic [1:0] {WST_IDLE, WST_DELAY, WST_FIRE} wst_idly_e;
endpackage

// file: wst_timers.sv
// Wake handling, host silence timer, pause timer and receive interrupt delay
`timescale 1ns/1ps
module wst_timers #(
  parameter int HNR_W = wst_pkg::HNR_W,
  parameter int IDLY_W = wst_pkg::IDLY_W
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic WAKE_ACTION_I,
  input wire logic [wst_pkg::RULE_W-1:0] WAKE_RULE_I,
  input wire logic [wst_pkg::PS_W-1:0] POWER_STATE_FIELD_I,
  input wire logic WAKE_OUTPUT_ENABLE_I,
  input wire logic WAKE_CLEAR_BIT_I,
  input wire logic [HNR_W-1:0] HOST_SILENCE_COUNT_I,
  input wire logic TX_READY_CLEAR_I,
  input wire logic START_PAUSE_I,
  input wire logic PAUSE_FRAME_I,
  input wire logic [wst_pkg::PAUSE_W-1:0] PAUSE_VALUE_I,
  input wire logic [IDLY_W-1:0] IRQ_DELAY_COUNT_I,
  input wire logic RX_BYTE_TICK_I,
  input wire logic RX_FIRST_DATA_I,
  input wire logic RX_IRQ_ACK_I,
  output logic POWER_EVENT_OUT_N_O,
  output logic HIR_WAKE_O,
  output logic WAKE_PENDING_O,
  output logic [wst_pkg::RULE_W-1:0] WAKE_RULE_STATUS_O,
  output logic TX_READY_FLAG_O,
  output logic PAUSE_ACTIVE_O,
  output logic RX_IRQ_O
);
  wst_cnt_if #(.W(HNR_W)) hnr_c ();
  wst_cnt_if #(.W(wst_pkg::PAUSE_W)) pause_c ();
  logic wake_pending;
  logic next_wake_pending;
  logic hir_wake;
  logic next_hir_wake;
  logic event_n;
  logic next_event_n;
  logic [wst_pkg::RULE_W-1:0] wake_rule;
  logic [wst_pkg::RULE_W-1:0] next_wake_rule;
  logic tx_ready;
  logic next_tx_ready;
  logic pause_active;
  logic next_pause_active;
  logic valid_wake;
  wst_pkg::wst_idly_e idly_state;
  wst_pkg::wst_idly_e next_idly_state;
  logic [IDLY_W-1:0] idly_count;
  logic [IDLY_W-1:0] next_idly_count;
  logic rx_irq;
  logic next_rx_irq;

  // Only a classification wake, in a power-down state, counts
  assign valid_wake = WAKE_ACTION_I && (POWER_STATE_FIELD_I != wst_pkg::PS_ACTIVE);

  // Silence timer load on wake; it ticks every clock
  assign hnr_c.load = valid_wake;
  assign hnr_c.value = HOST_SILENCE_COUNT_I;

  // Pause counter load from local start or received pause frame
  assign pause_c.load = START_PAUSE_I || PAUSE_FRAME_I;
  assign pause_c.value = PAUSE_VALUE_I;

  wst_countdown #(.W(HNR_W)) u_hnr (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .tick_i(1'b1),
    .c(hnr_c)
  );

  wst_countdown #(.W(wst_pkg::PAUSE_W)) u_pause (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .tick_i(1'b1),
    .c(pause_c)
  );

  // Wake event state; a new wake wins over a clear in the same cycle
  always_comb begin
    next_wake_pending = wake_pending;
    next_hir_wake = hir_wake;
    next_event_n = event_n;
    next_wake_rule = wake_rule;
    next_tx_ready = tx_ready;
    if (WAKE_CLEAR_BIT_I) begin
      next_wake_pending = 1'b0;
      next_hir_wake = 1'b0;
      next_event_n = 1'b1;
    end
    if (valid_wake) begin
      next_wake_pending = 1'b1;
      next_wake_rule = WAKE_RULE_I;
      if (WAKE_OUTPUT_ENABLE_I) begin
        next_event_n = 1'b0;
      end else begin
        next_hir_wake = 1'b1;
      end
    end
    if (TX_READY_CLEAR_I) begin
      next_tx_ready = 1'b0;
    end
    if (hnr_c.expire && wake_pending && !WAKE_CLEAR_BIT_I) begin
      next_tx_ready = 1'b1;
    end
  end

  // Wake event registers
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      wake_pending <= 1'b0;
      hir_wake <= 1'b0;
      event_n <= 1'b1;
      wake_rule <= wst_pkg::RULE_RST;
      tx_ready <= 1'b0;
    end else begin
      wake_pending <= next_wake_pending;
      hir_wake <= next_hir_wake;
      event_n <= next_event_n;
      wake_rule <= next_wake_rule;
      tx_ready <= next_tx_ready;
    end
  end

  // Pause state follows the counter; ends the cycle after it reaches zero
  always_comb begin
    next_pause_active = pause_c.busy || pause_c.load;
    if (pause_c.load && PAUSE_VALUE_I == wst_pkg::PAUSE_RST) begin
      next_pause_active = 1'b0;
    end
  end

  // Pause state register
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      pause_active <= 1'b0;
    end else begin
      pause_active <= next_pause_active;
    end
  end

  // Receive interrupt delay: counts byte times after first queued data
  always_comb begin
    next_idly_state = idly_state;
    next_idly_count = idly_count;
    next_rx_irq = rx_irq;
    if (RX_IRQ_ACK_I) begin
      next_rx_irq = 1'b0;
    end
    unique case (idly_state)
      wst_pkg::WST_IDLE: begin
        if (RX_FIRST_DATA_I) begin
          next_idly_count = IRQ_DELAY_COUNT_I;
          next_idly_state = wst_pkg::WST_DELAY;
        end
      end
      wst_pkg::WST_DELAY: begin
        if (idly_count == wst_pkg::IDLY_RST) begin
          next_idly_state = wst_pkg::WST_FIRE;
        end else if (RX_BYTE_TICK_I) begin
          next_idly_count = idly_count - {{(IDLY_W-1){1'b0}}, 1'b1};
        end
      end
      wst_pkg::WST_FIRE: begin
        next_rx_irq = 1'b1;
        next_idly_state = wst_pkg::WST_IDLE;
      end
    endcase
  end

  // Interrupt delay registers
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      idly_state <= wst_pkg::WST_IDLE;
      idly_count <= wst_pkg::IDLY_RST;
      rx_irq <= 1'b0;
    end else begin
      idly_state <= next_idly_state;
      idly_count <= next_idly_count;
      rx_irq <= next_rx_irq;
    end
  end

  // Outputs straight from flip-flops
  assign POWER_EVENT_OUT_N_O = event_n;
  assign HIR_WAKE_O = hir_wake;
  assign WAKE_PENDING_O = wake_pending;
  assign WAKE_RULE_STATUS_O = wake_rule;
  assign TX_READY_FLAG_O = tx_ready;
  assign PAUSE_ACTIVE_O = pause_active;
  assign RX_IRQ_O = rx_irq;
endmodule // wst_timers

// file: wst_timers_sva.sv
// Checker of wake, silence timer and pause behaviour at the top ports
`timescale 1ns/1ps
module wst_timers_chk (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic WAKE_ACTION_I,
  input wire logic [6:0] WAKE_RULE_I,
  input wire logic [1:0] POWER_STATE_FIELD_I,
  input wire logic WAKE_OUTPUT_ENABLE_I,
  input wire logic WAKE_CLEAR_BIT_I,
  input wire logic START_PAUSE_I,
  input wire logic [15:0] PAUSE_VALUE_I,
  input wire logic POWER_EVENT_OUT_N_O,
  input wire logic HIR_WAKE_O,
  input wire logic WAKE_PENDING_O,
  input wire logic [6:0] WAKE_RULE_STATUS_O,
  input wire logic TX_READY_FLAG_O,
  input wire logic PAUSE_ACTIVE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  wire valid = WAKE_ACTION_I && POWER_STATE_FIELD_I != 2'h0;
  // Wake handling, ready flag and pause start
  chk_wake_needs_down: assert property ($rose(WAKE_PENDING_O) |->
    $past(POWER_STATE_FIELD_I) != 2'h0) else $error("wake taken while active");
  chk_pin_on_wake: assert property (valid && WAKE_OUTPUT_ENABLE_I |=>
    !POWER_EVENT_OUT_N_O) else $error("event pin not driven");
  chk_irq_on_wake: assert property (valid && !WAKE_OUTPUT_ENABLE_I |=>
    HIR_WAKE_O) else $error("interrupt wake bit not set");
  chk_rule_capture: assert property (valid |=> WAKE_PENDING_O &&
    WAKE_RULE_STATUS_O == $past(WAKE_RULE_I)) else $error("rule not captured");
  chk_clear_drops: assert property (WAKE_CLEAR_BIT_I && !WAKE_ACTION_I |=>
    !WAKE_PENDING_O && !HIR_WAKE_O && POWER_EVENT_OUT_N_O) else $error("clear ignored");
  chk_ready_cause: assert property ($rose(TX_READY_FLAG_O) |->
    $past(WAKE_PENDING_O)) else $error("ready flag without pending wake");
  chk_pin_cause: assert property ($fell(POWER_EVENT_OUT_N_O) |->
    $past(WAKE_ACTION_I)) else $error("event pin without wake action");
  chk_pause_start: assert property (START_PAUSE_I && PAUSE_VALUE_I != 16'h0000 |=>
    PAUSE_ACTIVE_O) else $error("pause not entered");
  // Main scenarios reached
  cover property (!POWER_EVENT_OUT_N_O);
  cover property ($rose(TX_READY_FLAG_O));
  cover property ($fell(PAUSE_ACTIVE_O));
endmodule // wst_timers_chk
bind wst_timers wst_timers_chk wst_timers_chk_inst (.*);
